// ### rtl/usb_dc_setup_cmd.v
// Purpose: Command interpreter for endpoint setup and general commands
// Assumes: Strobes and data come from pins and are synchronised here
// Summary of operation
// - Codes A0..AF return error code of endpoints 0..15 as one read
// - Code B0 plus one word write unlocks all writable registers
// - In 16-bit mode N bytes take (N+1)/2 words, last may be partial
// - Status copy reads return status without clearing anything
// - 8-bit register read in 16-bit mode: upper byte unusable
// - Setup written by 20..2F, read by 30..3F, one word each
// - A USB bus reset disables every endpoint
// - Allocation waits for in-order setup of all 16, starts after last
// - A change to size or enable invalidates every endpoint buffer
// - Setup register 8 bits RW, fields at 7,6,5,4,3..0, reset zero
// - Enable bit set allocates buffer; clear means none allocated
// - Direction bit: 0 is OUT, 1 is IN
// - Double-buffer bit gives two alternating buffers
// - Type bit set is isochronous, clear is bulk or interrupt
`timescale 1ns/1ps
`include "usb_dc_cmd_consts.vh"

module usb_dc_setup_cmd
(
   input  wire         REF_CLK_IN,
   input  wire         RST_IN,
   input  wire         CMD_STB_IN,
   input  wire         WR_STB_IN,
   input  wire         RD_STB_IN,
   input  wire [15:0]  DATA_IN,
   input  wire         BUS16_IN,
   input  wire         LOCK_REQ_IN,
   input  wire         USB_BUS_RESET_IN,
   input  wire [127:0] ERROR_CODES_IN,
   input  wire [127:0] STATUS_IN,
   input  wire [9:0]   XFER_BYTES_IN,
   output reg  [15:0]  DATA_OUT,
   output reg          LOCKED_OUT,
   output wire [127:0] SETUP_OUT,
   output wire [15:0]  BUFFER_ON_OUT,
   output wire [15:0]  DIRECTION_IN_OUT,
   output wire [15:0]  TWO_BUFFERS_OUT,
   output wire [15:0]  ISOCHRONOUS_OUT,
   output wire         ALLOC_START_OUT,
   output wire         ALLOCATED_OUT,
   output wire         INVALIDATE_OUT,
   output wire [9:0]   XFER_ACCESSES_OUT,
   output wire         XFER_PARTIAL_OUT
);

   // -------------------------------------------------------------------
   // States
   // -------------------------------------------------------------------
   localparam [2:0] ST_IDLE    = 3'b001;
   localparam [2:0] ST_WR_DATA = 3'b010;
   localparam [2:0] ST_RD_DATA = 3'b100;

   // -------------------------------------------------------------------
   // Synchronisers for pin inputs
   // -------------------------------------------------------------------
   reg  [2:0]  cmd_sync;
   reg  [2:0]  wr_sync;
   reg  [2:0]  rd_sync;
   reg  [15:0] data_s1;
   reg  [15:0] data_s2;
   reg  [1:0]  bus16_sync;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [7:0]  cmd;
   reg         unlock_low_seen;
   reg         setup_wr;
   reg         bus16;
   reg  [7:0]  sel_byte;

   wire        cmd_edge;
   wire        wr_edge;
   wire        rd_edge;
   wire [3:0]  cmd_grp;
   wire [3:0]  cmd_ep;

   // Three stages per strobe, two for data and width: stage one feeds only stage two, edges use 2 and 3
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         cmd_sync   <= 3'b000;
         wr_sync    <= 3'b000;
         rd_sync    <= 3'b000;
         data_s1    <= 16'h0000;
         data_s2    <= 16'h0000;
         bus16_sync <= 2'b00;
      end
      else
      begin
         cmd_sync   <= {cmd_sync[1:0], CMD_STB_IN};
         wr_sync    <= {wr_sync[1:0], WR_STB_IN};
         rd_sync    <= {rd_sync[1:0], RD_STB_IN};
         data_s1    <= DATA_IN;
         data_s2    <= data_s1;
         bus16_sync <= {bus16_sync[0], BUS16_IN};
      end
   end

   // Rising edges after synchronisation
   assign cmd_edge = cmd_sync[1] & ~cmd_sync[2];
   assign wr_edge  = wr_sync[1] & ~wr_sync[2];
   assign rd_edge  = rd_sync[1] & ~rd_sync[2];

   always @*
   begin
      bus16 = bus16_sync[1];
   end

   assign cmd_grp = cmd[7:4];
   assign cmd_ep  = cmd[3:0];

   // Byte of a flat 16-entry table
   function [7:0] pick_byte;
      input [127:0] table_v;
      input [3:0]   idx;
      begin
         pick_byte = table_v[idx*8 +: 8];
      end
   endfunction

   // Does the command expect a data write or a data read
   function is_write_cmd;
      input [7:0] code;
      begin
         is_write_cmd = (code[7:4] == `CMD_SETUP_WR_GRP)
                        || (code == `CMD_UNLOCK);
      end
   endfunction

   function is_read_cmd;
      input [7:0] code;
      begin
         is_read_cmd = (code[7:4] == `CMD_SETUP_RD_GRP)
                       || (code[7:4] == `CMD_ERR_RD_GRP)
                       || (code[7:4] == `CMD_STAT_COPY_GRP);
      end
   endfunction

   // -------------------------------------------------------------------
   // Command sequencer
   // -------------------------------------------------------------------
   // A new command always wins, so a dropped data phase cannot wedge us
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE,
         ST_WR_DATA,
         ST_RD_DATA:
         begin
            if (cmd_edge)
            begin
               if (is_write_cmd(data_s2[7:0]))
                  next_state = ST_WR_DATA;
               else if (is_read_cmd(data_s2[7:0]))
                  next_state = ST_RD_DATA;
               else
                  next_state = ST_IDLE;
            end
            else if ((state == ST_WR_DATA) && wr_edge)
            begin
               // 8-bit unlock needs both bytes of the word
               if ((cmd == `CMD_UNLOCK) && !bus16 && !unlock_low_seen)
                  next_state = ST_WR_DATA;
               else
                  next_state = ST_IDLE;
            end
            else if ((state == ST_RD_DATA) && rd_edge)
               next_state = ST_IDLE;
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         state <= ST_IDLE;
         cmd   <= 8'h00;
      end
      else
      begin
         state <= next_state;
         if (cmd_edge)
            cmd <= data_s2[7:0];
      end
   end

   // -------------------------------------------------------------------
   // Read data selection
   // -------------------------------------------------------------------
   // Status copy is a plain look; nothing is cleared on the way out
   always @*
   begin
      case (data_s2[7:4])
         `CMD_SETUP_RD_GRP:
            sel_byte = pick_byte(SETUP_OUT, data_s2[3:0]);
         `CMD_ERR_RD_GRP:
            sel_byte = pick_byte(ERROR_CODES_IN, data_s2[3:0]);
         `CMD_STAT_COPY_GRP:
            sel_byte = pick_byte(STATUS_IN, data_s2[3:0]);
         default:
            sel_byte = 8'h00;
      endcase
   end

   // Data is latched at command time and held through the read strobe
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
         DATA_OUT <= 16'h0000;
      else if (cmd_edge && is_read_cmd(data_s2[7:0]))
         DATA_OUT <= {8'h00, sel_byte};     // Upper byte zero
   end

   // -------------------------------------------------------------------
   // Write lock and unlock
   // -------------------------------------------------------------------
   // Any data word unlocks; the value is not checked
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         LOCKED_OUT      <= 1'b0;
         unlock_low_seen <= 1'b0;
      end
      else
      begin
         if (cmd_edge)
            unlock_low_seen <= 1'b0;
         if ((state == ST_WR_DATA) && wr_edge && (cmd == `CMD_UNLOCK)
             && !cmd_edge)
         begin
            if (bus16 || unlock_low_seen)
            begin
               LOCKED_OUT      <= 1'b0;
               unlock_low_seen <= 1'b0;
            end
            else
               unlock_low_seen <= 1'b1;
         end
         else if (LOCK_REQ_IN)
            LOCKED_OUT <= 1'b1;
      end
   end

   // Setup writes go through only while unlocked
   always @*
   begin
      setup_wr = (state == ST_WR_DATA) && wr_edge && !cmd_edge
                 && (cmd_grp == `CMD_SETUP_WR_GRP) && !LOCKED_OUT;
   end

   // -------------------------------------------------------------------
   // Endpoint setup storage and allocation
   // -------------------------------------------------------------------
   ep_setup_bank u_bank
   (
      .clk         (REF_CLK_IN),
      .rst         (RST_IN),
      .wr          (setup_wr),
      .idx         (cmd_ep),
      .wdata       (data_s2[7:0]),
      .bus_reset   (USB_BUS_RESET_IN),
      .setup_flat  (SETUP_OUT),
      .alloc_start (ALLOC_START_OUT),
      .allocated   (ALLOCATED_OUT),
      .invalidate  (INVALIDATE_OUT)
   );

   // Per-endpoint field views for the data path
   genvar g;
   generate
      for (g = 0; g < `EP_COUNT; g = g + 1)
      begin : g_fields
         assign BUFFER_ON_OUT[g]    =
            SETUP_OUT[g*8+`SETUP_BUFFER_ON];
         assign DIRECTION_IN_OUT[g] =
            SETUP_OUT[g*8+`SETUP_DIRECTION];
         assign TWO_BUFFERS_OUT[g]  =
            SETUP_OUT[g*8+`SETUP_TWO_BUFFERS];
         assign ISOCHRONOUS_OUT[g]  =
            SETUP_OUT[g*8+`SETUP_ISO_TYPE];
      end
   endgenerate

   // -------------------------------------------------------------------
   // Transfer length in bus accesses
   // -------------------------------------------------------------------
   xfer_word_count u_count
   (
      .clk          (REF_CLK_IN),
      .rst          (RST_IN),
      .bus16        (bus16),
      .bytes        (XFER_BYTES_IN),
      .accesses     (XFER_ACCESSES_OUT),
      .last_partial (XFER_PARTIAL_OUT)
   );

endmodule // usb_dc_setup_cmd

// ### pkg/usb_dc_cmd_consts.vh
// Purpose: Shared constants of the endpoint setup command interpreter
// Assumes: Included by bare name from the rtl files
// Notes:   Definitions only
`ifndef USB_DC_CMD_CONSTS_VH
`define USB_DC_CMD_CONSTS_VH

// -----------------------------------------------------------------------
// Command codes (upper nibble selects the group, lower the endpoint)
// -----------------------------------------------------------------------
`define CMD_SETUP_WR_GRP   4'h2
`define CMD_SETUP_RD_GRP   4'h3
`define CMD_ERR_RD_GRP     4'hA
`define CMD_STAT_COPY_GRP  4'hD
`define CMD_UNLOCK         8'hB0

// -----------------------------------------------------------------------
// Endpoint setup register fields
// -----------------------------------------------------------------------
`define SETUP_BUFFER_ON    7
`define SETUP_DIRECTION    6
`define SETUP_TWO_BUFFERS  5
`define SETUP_ISO_TYPE     4
`define SETUP_SIZE_HI      3
`define SETUP_SIZE_LO      0
`define SETUP_RESET        8'h00

// -----------------------------------------------------------------------
// Endpoint count and sequence end
// -----------------------------------------------------------------------
`define EP_COUNT           16
`define EP_LAST_INDEX      4'hF
`define EP_FIRST_INDEX     4'h0

`endif

// ### rtl/ep_setup_bank.v
// Purpose: Holds the sixteen endpoint setup registers and allocation state
// Assumes: One write at a time from the command interpreter
// Notes:   Allocation starts only after an in-order write of all entries
`timescale 1ns/1ps
`include "usb_dc_cmd_consts.vh"

module ep_setup_bank
(
   input  wire         clk,
   input  wire         rst,
   input  wire         wr,
   input  wire [3:0]   idx,
   input  wire [7:0]   wdata,
   input  wire         bus_reset,
   output reg  [127:0] setup_flat,
   output reg          alloc_start,
   output reg          allocated,
   output reg          invalidate
);

   reg [7:0] setup_mem [0:15];
   reg [3:0] seq_next;          // Next endpoint expected in the sequence
   integer   i;                 // Loop index of the clocked process only
   integer   k;                 // Loop index of the flat view only

   // Changed size or enable alters the memory map
   function touches_memory;
      input [7:0] old_v;
      input [7:0] new_v;
      begin
         touches_memory = (old_v[`SETUP_BUFFER_ON] != new_v[`SETUP_BUFFER_ON])
            || (old_v[`SETUP_SIZE_HI:`SETUP_SIZE_LO]
                != new_v[`SETUP_SIZE_HI:`SETUP_SIZE_LO]);
      end
   endfunction

   // -------------------------------------------------------------------
   // Register array, sequence tracker and allocation
   // -------------------------------------------------------------------
   always @(posedge clk)
   begin
      alloc_start <= 1'b0;
      invalidate  <= 1'b0;
      if (rst)
      begin
         for (i = 0; i < `EP_COUNT; i = i + 1)
            setup_mem[i] <= `SETUP_RESET;
         seq_next  <= `EP_FIRST_INDEX;
         allocated <= 1'b0;
      end
      else if (bus_reset)
      begin
         // Bus reset drops every endpoint; data held is gone too
         for (i = 0; i < `EP_COUNT; i = i + 1)
            setup_mem[i][`SETUP_BUFFER_ON] <= 1'b0;
         seq_next   <= `EP_FIRST_INDEX;
         allocated  <= 1'b0;
         invalidate <= allocated;
      end
      else if (wr)
      begin
         setup_mem[idx] <= wdata;
         if (allocated && touches_memory(setup_mem[idx], wdata))
            invalidate <= 1'b1;
         // Out-of-order write restarts the sequence
         if (idx == seq_next)
            seq_next <= seq_next + 4'h1;
         else if (idx == `EP_FIRST_INDEX)
            seq_next <= 4'h1;
         else
            seq_next <= `EP_FIRST_INDEX;
         if ((idx == seq_next) && (idx == `EP_LAST_INDEX))
         begin
            alloc_start <= 1'b1;
            allocated   <= 1'b1;
         end
      end
   end

   // Flat view of the array; own index so no variable has two writers
   always @*
   begin
      setup_flat = 128'h0;
      for (k = 0; k < `EP_COUNT; k = k + 1)
         setup_flat[k*8 +: 8] = setup_mem[k];
   end

endmodule // ep_setup_bank

// ### rtl/xfer_word_count.v
// Purpose: Converts a byte count into bus accesses for the current width
// Assumes: Byte count at most 1023
// Notes:   The partial flag marks an unused upper byte in the last word
`timescale 1ns/1ps

module xfer_word_count
(
   input  wire       clk,
   input  wire       rst,
   input  wire       bus16,
   input  wire [9:0] bytes,
   output reg  [9:0] accesses,
   output reg        last_partial
);

   // -------------------------------------------------------------------
   // Registered count: (N + 1) / 2 words in 16-bit mode, N otherwise
   // -------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (rst)
      begin
         accesses     <= 10'h000;
         last_partial <= 1'b0;
      end
      else if (bus16)
      begin
         accesses     <= bytes[9:1] + {9'h000, bytes[0]};
         last_partial <= bytes[0];
      end
      else
      begin
         accesses     <= bytes;
         last_partial <= 1'b0;
      end
   end

endmodule // xfer_word_count

// ### sim/usb_dc_setup_chk.sv
// Purpose: Port-level checks of the endpoint setup command interpreter
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module usb_dc_setup_chk
(
   input wire         REF_CLK_IN,
   input wire         RST_IN,
   input wire         BUS16_IN,
   input wire         LOCK_REQ_IN,
   input wire         USB_BUS_RESET_IN,
   input wire [9:0]   XFER_BYTES_IN,
   input wire [15:0]  DATA_OUT,
   input wire         LOCKED_OUT,
   input wire [127:0] SETUP_OUT,
   input wire [15:0]  BUFFER_ON_OUT,
   input wire [15:0]  DIRECTION_IN_OUT,
   input wire [15:0]  TWO_BUFFERS_OUT,
   input wire [15:0]  ISOCHRONOUS_OUT,
   input wire         ALLOC_START_OUT,
   input wire         ALLOCATED_OUT,
   input wire         INVALIDATE_OUT,
   input wire [9:0]   XFER_ACCESSES_OUT,
   input wire         XFER_PARTIAL_OUT
);
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   wire [10:0] words = ({1'b0, XFER_BYTES_IN} + 11'h001) >> 1;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   a_upper_zero: assert property (DATA_OUT[15:8] == 8'h00)
      else $error("read word upper byte not zero");
   a_bus_reset_off: assert property (USB_BUS_RESET_IN |=>
      BUFFER_ON_OUT == 16'h0000 && !ALLOCATED_OUT)
      else $error("endpoint still enabled after bus reset");
   a_alloc_start: assert property (ALLOC_START_OUT |=>
      !ALLOC_START_OUT && ALLOCATED_OUT)
      else $error("allocation start pulse wrong");
   a_inval_cause: assert property (INVALIDATE_OUT |->
      $past(ALLOCATED_OUT) ##1 !INVALIDATE_OUT)
      else $error("invalidate without allocation");
   a_lock_set: assert property (LOCK_REQ_IN |-> ##[1:2] LOCKED_OUT)
      else $error("lock request not taken");
   a_locked_hold: assert property (LOCKED_OUT && !USB_BUS_RESET_IN
      |=> $stable(SETUP_OUT))
      else $error("setup changed while locked");
   a_xfer_words: assert property
      (($stable(XFER_BYTES_IN) && $stable(BUS16_IN)) [*4] |->
      XFER_ACCESSES_OUT == (BUS16_IN ? words[9:0] : XFER_BYTES_IN) &&
      XFER_PARTIAL_OUT == (BUS16_IN & XFER_BYTES_IN[0]))
      else $error("access count wrong");
   genvar g;
   // Each flag vector must mirror its bit of the setup byte
   for (g = 0; g < 16; g = g + 1)
   begin : g_map
      a_field_map: assert property (
         BUFFER_ON_OUT[g] == SETUP_OUT[8*g+7] &&
         DIRECTION_IN_OUT[g] == SETUP_OUT[8*g+6] &&
         TWO_BUFFERS_OUT[g] == SETUP_OUT[8*g+5] &&
         ISOCHRONOUS_OUT[g] == SETUP_OUT[8*g+4])
         else $error("flag vector differs from setup byte");
   end
   c_alloc: cover property (ALLOC_START_OUT);
   c_inval: cover property (INVALIDATE_OUT);
   c_unlock: cover property ($fell(LOCKED_OUT));
endmodule // usb_dc_setup_chk

bind usb_dc_setup_cmd usb_dc_setup_chk u_chk(.REF_CLK_IN, .RST_IN,
   .BUS16_IN, .LOCK_REQ_IN, .USB_BUS_RESET_IN, .XFER_BYTES_IN, .DATA_OUT,
   .LOCKED_OUT, .SETUP_OUT, .BUFFER_ON_OUT, .DIRECTION_IN_OUT,
   .TWO_BUFFERS_OUT, .ISOCHRONOUS_OUT, .ALLOC_START_OUT, .ALLOCATED_OUT,
   .INVALIDATE_OUT, .XFER_ACCESSES_OUT, .XFER_PARTIAL_OUT);

// ### sim/host_bus_model.sv
// Purpose: Processor side of the strobed command and data bus
// Assumes: Strobes are sampled through a three-flop synchroniser
// Notes:   Data shows the inverse of the last word between accesses
`timescale 1ns/1ps
module host_bus_model
(
   input  wire        clk_in,
   output reg         cmd_stb_out,
   output reg         wr_stb_out,
   output reg         rd_stb_out,
   output reg  [15:0] data_out
);
   initial
   begin
      cmd_stb_out = 1'b0;
      wr_stb_out  = 1'b0;
      rd_stb_out  = 1'b0;
      data_out    = 16'h0000;
   end

   // One access: 0 command, 1 write, 2 read; data settles before strobe
   // Only setup, read and unlock codes are ever issued
   task access(input [1:0] kind, input [15:0] val);
   begin
      @(posedge clk_in) #1 data_out = val;
      repeat (3) @(posedge clk_in);
      #1 cmd_stb_out = (kind == 2'd0);
      wr_stb_out = (kind == 2'd1);
      rd_stb_out = (kind == 2'd2);
      repeat (4) @(posedge clk_in);
      #1 cmd_stb_out = 1'b0;
      wr_stb_out = 1'b0;
      rd_stb_out = 1'b0;
      data_out = ~val;
      repeat (4) @(posedge clk_in);
   end
   endtask
endmodule // host_bus_model

// ### sim/tb_top.sv
// Purpose: Self-checking bench of the endpoint setup command interpreter
// Assumes: Host model drives strobes; bench drives the rest after edges
// Notes:   Bench keeps its own copy of the sixteen setup bytes
`timescale 1ns/1ps
module tb_top;
   localparam [7:0] CTRL_DEFAULT = 8'h83; // Plain control endpoint value
   reg          REF_CLK_IN, RST_IN, BUS16_IN, LOCK_REQ_IN, USB_BUS_RESET_IN;
   reg  [127:0] ERROR_CODES_IN, STATUS_IN;
   reg  [9:0]   XFER_BYTES_IN;
   wire         CMD_STB_IN, WR_STB_IN, RD_STB_IN, LOCKED_OUT, INVALIDATE_OUT;
   wire [15:0]  DATA_IN, DATA_OUT, BUFFER_ON_OUT, DIRECTION_IN_OUT;
   wire [15:0]  TWO_BUFFERS_OUT, ISOCHRONOUS_OUT;
   wire [127:0] SETUP_OUT;
   wire         ALLOC_START_OUT, ALLOCATED_OUT, XFER_PARTIAL_OUT;
   wire [9:0]   XFER_ACCESSES_OUT;
   integer      seed, bad_count, checks, inv_n, start_n, exp_inv, exp_start;
   integer      seq, i;
   reg  [7:0]   m_setup [0:15];
   reg          m_alloc, m_lock;

   host_bus_model u_host(.clk_in(REF_CLK_IN), .cmd_stb_out(CMD_STB_IN),
      .wr_stb_out(WR_STB_IN), .rd_stb_out(RD_STB_IN), .data_out(DATA_IN));
   usb_dc_setup_cmd u_dut(.REF_CLK_IN, .RST_IN, .CMD_STB_IN, .WR_STB_IN,
      .RD_STB_IN, .DATA_IN, .BUS16_IN, .LOCK_REQ_IN, .USB_BUS_RESET_IN,
      .ERROR_CODES_IN, .STATUS_IN, .XFER_BYTES_IN, .DATA_OUT, .LOCKED_OUT,
      .SETUP_OUT, .BUFFER_ON_OUT, .DIRECTION_IN_OUT, .TWO_BUFFERS_OUT,
      .ISOCHRONOUS_OUT, .ALLOC_START_OUT, .ALLOCATED_OUT, .INVALIDATE_OUT,
      .XFER_ACCESSES_OUT, .XFER_PARTIAL_OUT);

   initial
   begin
      REF_CLK_IN = 1'b0;
      forever #2.5 REF_CLK_IN = ~REF_CLK_IN;
   end

   // Pulses are counted so that checks need not hit the exact cycle
   always @(posedge REF_CLK_IN)
   begin
      if (INVALIDATE_OUT === 1'b1) inv_n <= inv_n + 1;
      if (ALLOC_START_OUT === 1'b1) start_n <= start_n + 1;
   end

   // -------------------------------------------------------------------
   // Model and comparison helpers
   // -------------------------------------------------------------------
   function [127:0] bank(input integer b);
      integer j;
      begin
         for (j = 0; j < 16; j = j + 1) bank[8*j+:8] = m_setup[j];
      end
   endfunction
   function [15:0] field(input integer b);
      integer j;
      begin
         for (j = 0; j < 16; j = j + 1) field[j] = m_setup[j][b];
      end
   endfunction
   task check_word(input [15:0] got, input [15:0] exp);
   begin
      checks = checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: word %h, model %h", $time, got, exp);
      end
   end
   endtask
   task check_bank(input [127:0] got);
   begin
      checks = checks + 1;
      if (got !== bank(0)) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: setup bank %h", $time, got);
      end
   end
   endtask
   task check_state;
   begin
      check_bank(SETUP_OUT);
      check_word(inv_n, exp_inv);
      check_word(ALLOCATED_OUT, m_alloc);
      check_word(BUFFER_ON_OUT, field(7));
      check_word(DIRECTION_IN_OUT, field(6));
      check_word(TWO_BUFFERS_OUT, field(5));
      check_word(ISOCHRONOUS_OUT, field(4));
   end
   endtask
   task setup_wr(input [3:0] k, input [7:0] val);
   begin
      if (!m_lock) begin
         if (m_alloc && (m_setup[k][7] != val[7] ||
             m_setup[k][3:0] != val[3:0])) exp_inv = exp_inv + 1;
         m_setup[k] = val;
         seq = (k == seq) ? seq + 1 : (k == 0) ? 1 : 0;
         if (seq == 16) begin
            m_alloc = 1'b1;
            exp_start = exp_start + 1;
            seq = 0;
         end
      end
      u_host.access(2'd0, {8'h00, 4'h2, k});
      u_host.access(2'd1, {8'h00, val});
      check_state;
   end
   endtask
   task cmd_rd(input [7:0] code, input [7:0] exp);
   begin
      u_host.access(2'd0, {8'h00, code});
      u_host.access(2'd2, $random(seed));
      check_word(DATA_OUT, {8'h00, exp});
   end
   endtask
   task give_verdict;
   begin
      $display("mismatches %0d, comparisons %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask

   // Watchdog on the whole run
   initial
   begin
      repeat (90000) @(posedge REF_CLK_IN);
      bad_count = bad_count + 1;
      give_verdict;
   end

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial
   begin
      {seed, bad_count, checks, inv_n, start_n} = {32'd21, 128'd0};
      {exp_inv, exp_start, seq, m_alloc, m_lock} = {96'd0, 2'b00};
      {RST_IN, BUS16_IN, LOCK_REQ_IN, USB_BUS_RESET_IN} = 4'b1100;
      XFER_BYTES_IN = 10'h000;
      for (i = 0; i < 16; i = i + 1) m_setup[i] = 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
         ERROR_CODES_IN[32*i+:32] = $random(seed);
         STATUS_IN[32*i+:32] = $random(seed);
      end
      repeat (6) @(posedge REF_CLK_IN);
      #1 RST_IN = 1'b0;
      check_state;
      // Whole sequence in order, control endpoints with defaults
      for (i = 0; i < 16; i = i + 1)
         setup_wr(i, (i < 2) ? CTRL_DEFAULT | (i << 6)
            : $random(seed));
      check_word(start_n, exp_start);
      for (i = 0; i < 16; i = i + 1) begin
         cmd_rd(8'h30 + i, m_setup[i]);
         cmd_rd(8'hA0 + i, ERROR_CODES_IN[8*i+:8]);
         cmd_rd(8'hD0 + i, STATUS_IN[8*i+:8]);
         cmd_rd(8'hD0 + i, STATUS_IN[8*i+:8]);
      end
      // Direction change keeps buffers, size or enable change drops them
      setup_wr(5, m_setup[5] ^ 8'h40);
      setup_wr(5, m_setup[5] ^ 8'h01);
      setup_wr(6, m_setup[6] ^ 8'h80);
      // Lock, refused write, unlock as two byte writes on the narrow bus
      @(posedge REF_CLK_IN) #1 LOCK_REQ_IN = 1'b1;
      @(posedge REF_CLK_IN) #1 LOCK_REQ_IN = 1'b0;
      m_lock = 1'b1;
      repeat (2) @(posedge REF_CLK_IN);
      check_word(LOCKED_OUT, 16'h0001);
      setup_wr(7, ~m_setup[7]);
      #1 BUS16_IN = 1'b0;
      u_host.access(2'd0, 16'h00B0);
      u_host.access(2'd1, $random(seed));
      u_host.access(2'd1, $random(seed));
      m_lock = 1'b0;
      check_word(LOCKED_OUT, 16'h0000);
      setup_wr(7, ~m_setup[7]);
      #1 BUS16_IN = 1'b1;
      // Bus reset turns every endpoint off
      @(posedge REF_CLK_IN) #1 USB_BUS_RESET_IN = 1'b1;
      @(posedge REF_CLK_IN) #1 USB_BUS_RESET_IN = 1'b0;
      for (i = 0; i < 16; i = i + 1) m_setup[i][7] = 1'b0;
      exp_inv = exp_inv + m_alloc;
      {m_alloc, seq} = 33'd0;
      repeat (2) @(posedge REF_CLK_IN);
      check_state;
      // Access counts on both widths, extremes first
      for (i = 0; i < 12; i = i + 1) begin
         @(posedge REF_CLK_IN) #1 BUS16_IN = i[0];
         XFER_BYTES_IN = (i < 2) ? 10'h3FF : (i < 4) ? 10'h000 : $random(seed);
         repeat (5) @(posedge REF_CLK_IN);
         check_word(XFER_ACCESSES_OUT, BUS16_IN ? (XFER_BYTES_IN + 1) / 2
            : XFER_BYTES_IN);
         check_word(XFER_PARTIAL_OUT, BUS16_IN & XFER_BYTES_IN[0]);
      end
      give_verdict;
   end
endmodule // tb_top
